/* File: rtl/ipcv_pkg.sv */
// Package for the IP settings checker: register map, reset values, classes.
// Assumes a 32-bit APB register bus; no other file-level dependencies.
package ipcv_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h00C;
  localparam logic [11:0] OFF_NEW_ADDR  = 12'h010;
  localparam logic [11:0] OFF_NEW_MASK  = 12'h014;
  localparam logic [11:0] OFF_CUR_ADDR  = 12'h018;
  localparam logic [11:0] OFF_CUR_MASK  = 12'h01C;
  localparam logic [11:0] OFF_SVC_PORT  = 12'h020;

  // Control register: bit 0 commits the pending settings
  localparam int CTRL_COMMIT_BIT = 0;

  // Status register fields
  localparam int ST_VALID_BIT    = 0;
  localparam int ST_TP_SEL_BIT   = 1;
  localparam int ST_CLASS_LSB    = 4;
  localparam int ST_ERR_LSB      = 8;

  // Interrupt status fields
  localparam int IRQ_ACCEPT_BIT  = 0;
  localparam int IRQ_REJECT_BIT  = 1;
  localparam int IRQ_PORTSW_BIT  = 2;
  localparam int IRQ_W           = 3;

  // Reset values
  localparam logic [31:0] RST_ADDR     = 32'h0000_0000;
  localparam logic [31:0] RST_MASK     = 32'h0000_0000;
  localparam logic [15:0] RST_SVC_PORT = 16'h05E1;  // 1505 decimal

  // First octet boundaries
  localparam logic [7:0] OCT_A_LO    = 8'h01;  // 1
  localparam logic [7:0] OCT_A_HI    = 8'h7E;  // 126
  localparam logic [7:0] OCT_LOOP    = 8'h7F;  // 127
  localparam logic [7:0] OCT_B_LO    = 8'h80;  // 128
  localparam logic [7:0] OCT_B_HI    = 8'hBF;  // 191
  localparam logic [7:0] OCT_C_LO    = 8'hC0;  // 192
  localparam logic [7:0] OCT_C_HI    = 8'hDF;  // 223
  localparam logic [7:0] OCT_D_PRINT = 8'hFE;  // 254

  // Least leading ones of a mask per class
  localparam logic [5:0] MASK_MIN_A = 6'd8;
  localparam logic [5:0] MASK_MIN_B = 6'd16;
  localparam logic [5:0] MASK_MIN_C = 6'd24;
  localparam logic [5:0] HOST_MIN_ZEROS = 6'd2;

  // Address class codes as shown in the status register
  typedef enum logic [1:0] {
    IPCV_CLS_NONE = 2'h0,
    IPCV_CLS_A    = 2'h1,
    IPCV_CLS_B    = 2'h2,
    IPCV_CLS_C    = 2'h3
  } ipcv_class_t;

  // Error bits, one per failed check
  localparam int ERR_W         = 7;
  localparam int ERR_CLASS     = 0;
  localparam int ERR_LOOPBACK  = 1;
  localparam int ERR_ALLZO     = 2;
  localparam int ERR_MASK_LEN  = 3;
  localparam int ERR_HOSTBITS  = 4;
  localparam int ERR_HOSTPART  = 5;
  localparam int ERR_CLASS_D   = 6;

endpackage

/* File: rtl/ipcv_checker.sv */
// Combinational checker for one address and mask pair.
// Assumes inputs are stable registers in the caller's clock domain.
`timescale 1ns/1ns
module ipcv_checker (
  input  wire logic [31:0]                 addr,
  input  wire logic [31:0]                 mask,
  output ipcv_pkg::ipcv_class_t            cls,
  output wire logic [ipcv_pkg::ERR_W-1:0]  err
);

  wire logic [7:0] oct_w = addr[31:24];  // see RULE_01
  wire logic       is_a  = (oct_w >= ipcv_pkg::OCT_A_LO) && (oct_w <= ipcv_pkg::OCT_A_HI);  // see RULE_02
  wire logic       is_b  = (oct_w >= ipcv_pkg::OCT_B_LO) && (oct_w <= ipcv_pkg::OCT_B_HI);
  wire logic       is_c  = (oct_w >= ipcv_pkg::OCT_C_LO) && (oct_w <= ipcv_pkg::OCT_C_HI);
  wire logic       is_lb = (oct_w == ipcv_pkg::OCT_LOOP);  // see RULE_04
  // Above 223 no class is given, so the printed 254 floor is covered too
  wire logic       is_d  = (oct_w > ipcv_pkg::OCT_C_HI) || (oct_w >= ipcv_pkg::OCT_D_PRINT);  // see RULE_05 see RULE_06

  // Count leading ones and total zeros of the mask
  logic [5:0] lead_ones;
  logic [5:0] zeros;
  logic       run;
  always_comb begin
    lead_ones = 6'd0;
    zeros     = 6'd0;
    run       = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      if (mask[i] && run) begin
        lead_ones = lead_ones + 6'd1;
      end else begin
        run = 1'b0;
      end
      if (!mask[i]) begin
        zeros = zeros + 6'd1;
      end
    end
  end

  wire logic [5:0]  need  = is_a ? ipcv_pkg::MASK_MIN_A :
                            is_b ? ipcv_pkg::MASK_MIN_B : ipcv_pkg::MASK_MIN_C;  // see RULE_03
  // Host part holds bits where the mask is zero
  wire logic [31:0] host  = addr & ~mask;  // see RULE_08
  wire logic        h_zero = (host == 32'h0000_0000);
  wire logic        h_ones = (host == ~mask);

  assign cls = is_a ? ipcv_pkg::IPCV_CLS_A :
               is_b ? ipcv_pkg::IPCV_CLS_B :
               is_c ? ipcv_pkg::IPCV_CLS_C : ipcv_pkg::IPCV_CLS_NONE;

  assign err[ipcv_pkg::ERR_CLASS]    = !(is_a || is_b || is_c);
  assign err[ipcv_pkg::ERR_LOOPBACK] = is_lb;
  assign err[ipcv_pkg::ERR_ALLZO]    = (addr == 32'h0000_0000) || (addr == 32'hFFFF_FFFF);  // see RULE_07
  assign err[ipcv_pkg::ERR_MASK_LEN] = lead_ones < need;  // see RULE_09 see RULE_10 see RULE_11
  assign err[ipcv_pkg::ERR_HOSTBITS] = zeros < ipcv_pkg::HOST_MIN_ZEROS;  // see RULE_12
  assign err[ipcv_pkg::ERR_HOSTPART] = h_zero || h_ones;  // see RULE_13
  assign err[ipcv_pkg::ERR_CLASS_D]  = is_d;

endmodule

/* File: rtl/ipcv_top.sv */
// Top of the IP settings checker: APB slave, settings store, port select, interrupt.
// Assumes an APB master on mclk and a link beat level synchronous to mclk.
`timescale 1ns/1ns

// How it works
// RULE_01: Address is 32 bits, four octets, first octet most significant.
// RULE_02: First octet 1-126 is class A, 128-191 B, 192-223 C.
// RULE_03: Class fixes default network part: one, two or three leading octets.
// RULE_04: First octet 127 is loopback and never a valid address.
// RULE_05: First octet above 223 gets no class A, B or C.
// RULE_06: Class D addresses, printed as from 254.0.0.0, are refused.
// RULE_07: All-zero and all-one addresses are refused.
// RULE_08: Mask ones mark network bits, zeros mark host bits.
// RULE_09: Class A needs at least 8 leading mask ones.
// RULE_10: Class B needs at least 16 leading mask ones.
// RULE_11: Class C needs at least 24 leading mask ones.
// RULE_12: Mask needs at least two zero bits.
// RULE_13: Host part of the address may not be zero or all ones.
// RULE_14: Service port is writable and resets to 1505.
// RULE_15: Twisted-pair port is chosen whenever its link beat is present.
// RULE_16: All checks give one verdict; failed settings leave old ones in place.
module ipcv_top (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_beat,
  output logic             twisted_pair_port_sel,
  output logic             attachment_unit_port_sel,
  output logic             cfg_valid,
  output logic             irq
);

  logic [31:0]                 new_addr_reg;
  logic [31:0]                 new_mask_reg;
  logic [31:0]                 cur_addr_reg;
  logic [31:0]                 cur_mask_reg;
  logic [15:0]                 svc_port_reg;
  logic                        valid_reg;
  logic [1:0]                  cls_reg;
  logic [ipcv_pkg::ERR_W-1:0]  err_reg;
  logic                        tp_sel_reg;
  logic [ipcv_pkg::IRQ_W-1:0]  irq_stat_reg;
  logic [ipcv_pkg::IRQ_W-1:0]  irq_mask_reg;
  logic                        commit_reg;

  ipcv_pkg::ipcv_class_t       chk_cls;
  wire logic [ipcv_pkg::ERR_W-1:0] chk_err;

  ipcv_checker u_chk (
    .addr (new_addr_reg),
    .mask (new_mask_reg),
    .cls  (chk_cls),
    .err  (chk_err)
  );

  // Bus decode
  wire logic acc     = psel && penable;
  wire logic wr_acc  = acc && pwrite;
  wire logic rd_setup = psel && !penable && !pwrite;
  wire logic hit_ctrl = (paddr == ipcv_pkg::OFF_CTRL);
  wire logic hit_stat = (paddr == ipcv_pkg::OFF_STATUS);
  wire logic hit_ist  = (paddr == ipcv_pkg::OFF_IRQ_STAT);
  wire logic hit_imk  = (paddr == ipcv_pkg::OFF_IRQ_MASK);
  wire logic hit_na   = (paddr == ipcv_pkg::OFF_NEW_ADDR);
  wire logic hit_nm   = (paddr == ipcv_pkg::OFF_NEW_MASK);
  wire logic hit_ca   = (paddr == ipcv_pkg::OFF_CUR_ADDR);
  wire logic hit_cm   = (paddr == ipcv_pkg::OFF_CUR_MASK);
  wire logic hit_sp   = (paddr == ipcv_pkg::OFF_SVC_PORT);
  wire logic hit_any  = hit_ctrl | hit_stat | hit_ist | hit_imk | hit_na | hit_nm | hit_ca | hit_cm | hit_sp;

  // Byte-lane merge for write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  wire logic [31:0] wmerge_na = merge(new_addr_reg, pwdata, pstrb);
  wire logic [31:0] wmerge_nm = merge(new_mask_reg, pwdata, pstrb);
  wire logic [31:0] wmerge_sp = merge({16'h0000, svc_port_reg}, pwdata, pstrb);

  // Commit is one cycle after the write so the checker sees stable settings
  wire logic commit_req = wr_acc && hit_ctrl && pstrb[0] && pwdata[ipcv_pkg::CTRL_COMMIT_BIT];
  wire logic chk_ok     = (chk_err == '0);  // see RULE_16
  wire logic accept_ev  = commit_reg && chk_ok;
  wire logic reject_ev  = commit_reg && !chk_ok;
  wire logic tp_next    = link_beat;  // see RULE_15
  wire logic portsw_ev  = (tp_next != tp_sel_reg);

  wire logic [ipcv_pkg::IRQ_W-1:0] ev_vec = {portsw_ev, reject_ev, accept_ev};
  wire logic [ipcv_pkg::IRQ_W-1:0] w1c    = (wr_acc && hit_ist && pstrb[0]) ?
                                           pwdata[ipcv_pkg::IRQ_W-1:0] : '0;
  // Set wins over a clear in the same cycle
  wire logic [ipcv_pkg::IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~w1c) | ev_vec;
  wire logic                       irq_next      = |(irq_stat_next & irq_mask_reg);

  wire logic [31:0] status_word = {16'h0000,
                                   1'b0, err_reg,
                                   2'b00, cls_reg,
                                   2'b00, tp_sel_reg, valid_reg};

  wire logic [31:0] rd_mux =
      hit_ctrl ? 32'h0000_0000 :
      hit_stat ? status_word :
      hit_ist  ? {29'h0, irq_stat_reg} :
      hit_imk  ? {29'h0, irq_mask_reg} :
      hit_na   ? new_addr_reg :
      hit_nm   ? new_mask_reg :
      hit_ca   ? cur_addr_reg :
      hit_cm   ? cur_mask_reg :
      hit_sp   ? {16'h0000, svc_port_reg} : 32'h0000_0000;

  // Bus answer: pready is registered and rises in the first access cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata  <= rd_setup ? rd_mux : prdata;
    end
  end

  // Pending settings and service port
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      new_addr_reg <= ipcv_pkg::RST_ADDR;
      new_mask_reg <= ipcv_pkg::RST_MASK;
      svc_port_reg <= ipcv_pkg::RST_SVC_PORT;  // see RULE_14
      irq_mask_reg <= '0;
    end else if (wr_acc && pready) begin
      if (hit_na) begin
        new_addr_reg <= wmerge_na;
      end
      if (hit_nm) begin
        new_mask_reg <= wmerge_nm;
      end
      if (hit_sp) begin
        svc_port_reg <= wmerge_sp[15:0];  // see RULE_14
      end
      if (hit_imk && pstrb[0]) begin
        irq_mask_reg <= pwdata[ipcv_pkg::IRQ_W-1:0];
      end
    end
  end

  // Active settings change only on a clean verdict
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      commit_reg   <= 1'b0;
      cur_addr_reg <= ipcv_pkg::RST_ADDR;
      cur_mask_reg <= ipcv_pkg::RST_MASK;
      valid_reg    <= 1'b0;
      cls_reg      <= 2'h0;
      err_reg      <= '0;
    end else begin
      commit_reg <= commit_req && pready;
      if (commit_reg) begin
        err_reg   <= chk_err;
        valid_reg <= chk_ok;  // see RULE_16
        if (chk_ok) begin
          cur_addr_reg <= new_addr_reg;
          cur_mask_reg <= new_mask_reg;
          cls_reg      <= chk_cls;
        end
      end
    end
  end

  // Port selection and interrupt
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tp_sel_reg               <= 1'b0;
      twisted_pair_port_sel    <= 1'b0;
      attachment_unit_port_sel <= 1'b1;
      irq_stat_reg             <= '0;
      irq                      <= 1'b0;
      cfg_valid                <= 1'b0;
    end else begin
      tp_sel_reg               <= tp_next;  // see RULE_15
      twisted_pair_port_sel    <= tp_next;
      attachment_unit_port_sel <= !tp_next;
      irq_stat_reg             <= irq_stat_next;
      irq                      <= irq_next;
      cfg_valid                <= commit_reg ? chk_ok : cfg_valid;
    end
  end

endmodule

/* File: dv/ipcv_top_properties.sv */
// Port checker for ipcv_top, bound onto every instance of it.
// Assumes an APB master that keeps the protocol and link_beat synchronous to mclk.
`timescale 1ns/1ns
module ipcv_top_properties (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        link_beat,
  input wire logic        twisted_pair_port_sel,
  input wire logic        attachment_unit_port_sel,
  input wire logic        cfg_valid,
  input wire logic        irq
);
  wire acc       = psel && penable && pready && pwrite;
  wire commit_wr = acc && paddr == ipcv_pkg::OFF_CTRL && pwdata[0] && pstrb[0];
  wire mask_wr   = acc && paddr == ipcv_pkg::OFF_IRQ_MASK;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_TP_FOLLOW: assert property (rstn |=> twisted_pair_port_sel == $past(link_beat))
    else $error("port select does not follow link beat");
  AST_PORT_EXCL: assert property (attachment_unit_port_sel != twisted_pair_port_sel)
    else $error("both or neither port selected");
  AST_CFG_HOLD: assert property ($changed(cfg_valid) |-> $past(commit_wr, 2))
    else $error("verdict changed without a commit");
  // Unmasking may reach irq one or two edges later, depending on where it is registered
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(commit_wr, 2) || $changed(twisted_pair_port_sel) || $past(mask_wr) || $past(mask_wr, 2))
    else $error("interrupt rose without a cause");
  AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  AST_PREADY_ACCESS: assert property (pready |-> psel && penable)
    else $error("answer outside an access cycle");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("answer held longer than one cycle");
  // Every register is one aligned word, so an offset off the word grid is unmapped as well
  AST_SLVERR_DECODE: assert property (pready |-> pslverr == ((paddr > ipcv_pkg::OFF_SVC_PORT) || (paddr[1:0] != 2'b00)))
    else $error("error response does not match address map");
endmodule

bind ipcv_top ipcv_top_properties u_props (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .link_beat, .twisted_pair_port_sel, .attachment_unit_port_sel, .cfg_valid, .irq);

/* File: dv/ipcv_top_test.sv */
// Self-checking bench for ipcv_top: APB traffic, settings commits, link beat, interrupt.
// Assumes the checker file is compiled with it and binds itself to the design.
`timescale 1ns/1ns
module ipcv_top_test;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic        link_beat = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, twisted_pair_port_sel, attachment_unit_port_sel, cfg_valid, irq;
  int          n_mismatch = 0;
  int          compares = 0;
  logic [31:0] cur_a = 32'h0000_0000;
  logic [31:0] cur_m = 32'h0000_0000;
  logic [2:0]  imask = 3'h0;
  logic [31:0] q, a;
  logic        er;
  logic [63:0] corners [12] = '{64'h0A00_0001_FF00_0000, 64'h7F00_0001_FF00_0000, 64'hE000_0001_FFFF_FF00,
    64'hFE00_0001_FFFF_FF00, 64'h0000_0000_FF00_0000, 64'hFFFF_FFFF_FFFF_FF00, 64'h8036_B161_FFFF_FF00,
    64'h8001_0001_FF00_0000, 64'hC0DF_B101_FFFF_0000, 64'hC0DF_B101_FFFF_FFFE, 64'hC0DF_B1FF_FFFF_FF00,
    64'hDF00_0102_FFFF_FFFC};

  always #5 mclk = ~mclk;

  ipcv_top dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .link_beat, .twisted_pair_port_sel, .attachment_unit_port_sel, .cfg_valid, .irq);

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held from setup until the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Read at each edge before that edge's updates land, so answer and data are taken together
    @(posedge mclk);
    for (n = 0; pready !== 1'b1; n++) begin
      if (n == 20) begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge mclk);
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [1:0] cls_of(input logic [7:0] w);
    if (w >= 8'd1 && w <= 8'd126) return 2'h1;
    if (w >= 8'd128 && w <= 8'd191) return 2'h2;
    if (w >= 8'd192 && w <= 8'd223) return 2'h3;
    return 2'h0;
  endfunction

  function automatic logic [6:0] errs_of(input logic [31:0] ad, input logic [31:0] m);
    logic [6:0] e;
    int         lead;
    lead = 0;
    while (lead < 32 && m[31-lead]) lead++;
    e = 7'h00;
    e[0] = cls_of(ad[31:24]) == 2'h0;
    e[1] = ad[31:24] == 8'd127;
    e[2] = ad == 32'h0000_0000 || ad == 32'hFFFF_FFFF;
    e[6] = ad[31:24] > 8'd223;
    // An address without a class is held to the longest mask need
    e[3] = lead < ((cls_of(ad[31:24]) == 2'h0) ? 24 : 8 * cls_of(ad[31:24]));
    e[4] = $countones(~m) < 2;
    e[5] = (ad & ~m) == 0 || (ad & ~m) == ~m;
    return e;
  endfunction

  task automatic commit(input logic [31:0] ad, input logic [31:0] m);
    logic [6:0] e;
    logic       v;
    e = errs_of(ad, m);
    v = e == 7'h00;
    apb(1'b1, ipcv_pkg::OFF_IRQ_STAT, 32'h0000_0007);
    apb(1'b1, ipcv_pkg::OFF_NEW_ADDR, ad);
    apb(1'b1, ipcv_pkg::OFF_NEW_MASK, m);
    apb(1'b1, ipcv_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    if (v) begin
      cur_a = ad;
      cur_m = m;
    end
    #1;
    chk(32'(cfg_valid), 32'(v));
    chk(32'(irq), 32'(|({!v, v} & imask[1:0])));
    apb(1'b0, ipcv_pkg::OFF_STATUS, 32'h0000_0000);
    chk(32'(q[0]), 32'(v));
    chk(32'(q[1]), 32'(link_beat));
    chk(32'(q[5:4]), 32'(cls_of(cur_a[31:24])));
    chk(32'(q[14:8]), 32'(e));
    if (!e[0]) chk(32'(q[14:8]), 32'(e));
    apb(1'b0, ipcv_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk(q & 32'h0000_0003, 32'({!v, v}));
    apb(1'b0, ipcv_pkg::OFF_CUR_ADDR, 32'h0000_0000);
    chk(q, cur_a);
    apb(1'b0, ipcv_pkg::OFF_CUR_MASK, 32'h0000_0000);
    chk(q, cur_m);
  endtask

  initial begin
    void'($urandom(42098));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    chk(32'({twisted_pair_port_sel, attachment_unit_port_sel, cfg_valid, irq, pready, pslverr}), 32'h0000_0010);
    apb(1'b0, ipcv_pkg::OFF_SVC_PORT, 32'h0000_0000);
    chk(q, 32'd1505);
    apb(1'b1, ipcv_pkg::OFF_SVC_PORT, 32'h0000_1234);
    apb(1'b0, ipcv_pkg::OFF_SVC_PORT, 32'h0000_0000);
    chk(q & 32'h0000_FFFF, 32'h0000_1234);
    // Only the low byte lane is enabled, the upper byte of the port must survive
    pstrb <= 4'h1;
    apb(1'b1, ipcv_pkg::OFF_SVC_PORT, 32'hABCD_5678);
    pstrb <= 4'hF;
    apb(1'b0, ipcv_pkg::OFF_SVC_PORT, 32'h0000_0000);
    chk(q, 32'h0000_1278);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    imask = 3'h3;
    apb(1'b1, ipcv_pkg::OFF_IRQ_MASK, 32'h0000_0003);
    foreach (corners[i]) commit(corners[i][63:32], corners[i][31:0]);
    imask = 3'h0;
    apb(1'b1, ipcv_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    repeat (40) begin
      a = $urandom;
      if (a[0]) a[31:24] = 8'hC0 + 8'($urandom % 32);
      commit(a, 32'hFFFF_FFFF << ($urandom % 25));
    end
    for (int i = 0; i < 4; i++) begin
      imask = {i[0], 2'b00};
      apb(1'b1, ipcv_pkg::OFF_IRQ_MASK, 32'(imask));
      link_beat <= ~link_beat;
      repeat (2) @(posedge mclk);
      #1;
      chk(32'(twisted_pair_port_sel), 32'(link_beat));
      chk(32'(attachment_unit_port_sel), 32'(!link_beat));
      chk(32'(irq), 32'(imask[2]));
      apb(1'b1, ipcv_pkg::OFF_IRQ_STAT, 32'h0000_0007);
      @(posedge mclk);
      #1;
      chk(32'(irq), 32'h0000_0000);
    end
    give_verdict();
  end
endmodule
